// File: core/safe_pkg.sv
// Package of register offsets, field positions and reset values for the smoke AFE amp control
package safe_pkg;

    // Avalon word offsets (byte address = 4 * index)
    localparam logic [2:0] SAFE_IDX_GAIN_FIRST  = 3'h0;  // First resistor code
    localparam logic [2:0] SAFE_IDX_GAIN_SECOND = 3'h1;  // Second and third resistor codes
    localparam logic [2:0] SAFE_IDX_AMP0_CTRL   = 3'h2;  // Amplifier 0 control
    localparam logic [2:0] SAFE_IDX_AMP1_CTRL   = 3'h3;  // Amplifier 1 control
    localparam logic [2:0] SAFE_IDX_AMP0_TRIM   = 3'h4;  // Amplifier 0 offset trim
    localparam logic [2:0] SAFE_IDX_AMP1_TRIM   = 3'h5;  // Amplifier 1 offset trim
    localparam int         SAFE_ADDR_W          = 3;     // Word address width

    // Field positions
    localparam int SAFE_CTRL_EN_BIT     = 6;   // Amplifier enable
    localparam int SAFE_CTRL_STATUS_BIT = 5;   // Read-only output status
    localparam int SAFE_TRIM_CAL_BIT    = 7;   // Calibration mode
    localparam int SAFE_TRIM_REF_BIT    = 6;   // Calibration reference select

    // Reset values
    localparam logic [7:0] SAFE_GAIN_FIRST_RST  = 8'h00;
    localparam logic [7:0] SAFE_GAIN_SECOND_RST = 8'h00;
    localparam logic [2:0] SAFE_CTRL_RST        = 3'h0;   // Enable and bandwidth bits
    localparam logic [7:0] SAFE_TRIM_RST        = 8'h20;  // Trim bit 5 set

    // Bandwidth codes
    localparam logic [1:0] SAFE_BW_5K   = 2'h0;
    localparam logic [1:0] SAFE_BW_40K  = 2'h1;
    localparam logic [1:0] SAFE_BW_600K = 2'h2;
    localparam logic [1:0] SAFE_BW_2M   = 2'h3;

    // Slave answer timing: one wait cycle per access
    localparam int SAFE_WAIT_CYCLES = 1;

endpackage : safe_pkg

// File: core/safe_amp_channel.sv
// One amplifier channel: control and trim fields plus synchronised status
`timescale 1ns/100ps
module safe_amp_channel
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Write strobes and data
    input  wire logic       ctrl_we,
    input  wire logic       trim_we,
    input  wire logic [7:0] wdata,
    // Analog side
    input  wire logic       amp_out_raw,
    // Register views
    output logic      [7:0] ctrl_rd,
    output logic      [7:0] trim_rd,
    output logic            enable,
    output logic      [1:0] bandwidth,
    output logic            cal_mode,
    output logic            cal_ref_select,
    output logic      [5:0] trim_value
);
    import safe_pkg::*;

    logic       enable_q;      // Amplifier on
    logic [1:0] bw_q;          // Bandwidth code
    logic [7:0] trim_q;        // Cal mode, ref select, trim
    logic       sync1_q;       // Synchroniser first stage
    logic       sync2_q;       // Synchroniser second stage

    ////////////////////////////////////////////////////////////////////////////
    // Control register fields
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enable_q <= SAFE_CTRL_RST[2];
            bw_q     <= SAFE_CTRL_RST[1:0];
        end
        else if (ctrl_we)
        begin
            // Status bit is read-only, writes to it are dropped
            enable_q <= wdata[SAFE_CTRL_EN_BIT];
            bw_q     <= wdata[1:0];
        end
    end

    // Trim register: whole byte writable
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            trim_q <= SAFE_TRIM_RST;
        else if (trim_we)
            trim_q <= wdata;
    end

    // Two-stage synchroniser for the comparator-like amp output
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end
        else
        begin
            sync1_q <= amp_out_raw;
            sync2_q <= sync1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read views; unimplemented bits are zero
    always_comb
    begin
        ctrl_rd    = 8'h00;
        ctrl_rd[SAFE_CTRL_EN_BIT] = enable_q;
        ctrl_rd[SAFE_CTRL_STATUS_BIT] = sync2_q & trim_q[SAFE_TRIM_CAL_BIT];
        ctrl_rd[1:0] = bw_q;
        trim_rd    = trim_q;
    end

    assign enable         = enable_q;
    assign bandwidth      = bw_q;
    assign cal_mode       = trim_q[SAFE_TRIM_CAL_BIT];
    assign cal_ref_select = trim_q[SAFE_TRIM_REF_BIT];
    assign trim_value     = trim_q[5:0];

    // Status must read low outside calibration mode
    status_low_a: assert property (@(posedge clk) disable iff (!rst_n)
        !trim_q[SAFE_TRIM_CAL_BIT] |-> !ctrl_rd[SAFE_CTRL_STATUS_BIT])
        else $error("status visible outside cal mode");

    // Raw level reaches status after two edges in cal mode
    status_sync_a: assert property (@(posedge clk) disable iff (!rst_n)
        (trim_q[SAFE_TRIM_CAL_BIT] && $stable(trim_q[SAFE_TRIM_CAL_BIT])
         ##0 $past(trim_q[SAFE_TRIM_CAL_BIT], 2))
        |-> ctrl_rd[SAFE_CTRL_STATUS_BIT] == $past(amp_out_raw, 2))
        else $error("status not two-stage synchronised");

endmodule : safe_amp_channel

// File: core/safe_amp_ctrl.sv
// Avalon-MM register bank controlling the two-amplifier smoke sensing front end
//
// Our own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
module safe_amp_ctrl
(
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    // Avalon-MM slave
    input  wire logic [safe_pkg::SAFE_ADDR_W-1:0] avs_address,
    input  wire logic                         avs_read,
    input  wire logic                         avs_write,
    input  wire logic [31:0]                  avs_writedata,
    input  wire logic [3:0]                   avs_byteenable,
    output logic      [31:0]                  avs_readdata,
    output logic      [1:0]                   avs_response,
    output logic                              avs_waitrequest,
    // Amplifier status from the analog side
    input  wire logic                         amp0_output_status,
    input  wire logic                         amp1_output_status,
    // Analog control lines
    output logic      [5:0]                   first_resistor_code,
    output logic      [5:0]                   second_resistor_code,
    output logic      [1:0]                   third_resistor_code,
    output logic                              amp0_enable,
    output logic                              amp1_enable,
    output logic      [1:0]                   amp0_bandwidth,
    output logic      [1:0]                   amp1_bandwidth,
    output logic                              amp0_cal_mode,
    output logic                              amp1_cal_mode,
    output logic                              amp0_cal_ref_select,
    output logic                              amp1_cal_ref_select,
    output logic      [5:0]                   amp0_trim_value,
    output logic      [5:0]                   amp1_trim_value,
    output logic                              amp0_cal_switches,
    output logic                              amp1_cal_switches
);
    import safe_pkg::*;

    logic [5:0] gain_first_q;      // First resistor code
    logic [7:0] gain_second_q;     // Third (7:6) and second (5:0) codes
    logic       ack_q;             // Answer phase of an access
    logic       wr_hit;            // Write taken this cycle
    logic       lane0;             // Byte lane 0 enabled
    logic [7:0] rd_d;              // Read mux
    logic       map_ok;            // Address is mapped
    logic [7:0] c0_rd;
    logic [7:0] c1_rd;
    logic [7:0] t0_rd;
    logic [7:0] t1_rd;
    logic       a0_en;
    logic       a1_en;
    logic [1:0] a0_bw;
    logic [1:0] a1_bw;
    logic       a0_cal;
    logic       a1_cal;
    logic       a0_ref;
    logic       a1_ref;
    logic [5:0] a0_trim;
    logic [5:0] a1_trim;

    // Write strobe helper used for every register
    function automatic logic hit(input logic [SAFE_ADDR_W-1:0] a,
                                 input logic [SAFE_ADDR_W-1:0] idx);
        hit = (a == idx);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshake: waitrequest high for the first request cycle, low in the
    // second, so every access takes exactly two cycles. Keeps read data
    // registered without any combinational path from address to readdata.
    assign lane0  = avs_byteenable[0];
    assign wr_hit = avs_write & ~ack_q;
    assign map_ok = (avs_address <= SAFE_IDX_AMP1_TRIM);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ack_q <= 1'b0;
        else
            ack_q <= (avs_read | avs_write) & ~ack_q;
    end

    // Waitrequest registered: low only during the answer cycle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            avs_waitrequest <= 1'b1;
        else
            avs_waitrequest <= ~((avs_read | avs_write) & ~ack_q);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Gain registers, updated on the clock edge taking the write
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gain_first_q  <= SAFE_GAIN_FIRST_RST[5:0];
            gain_second_q <= SAFE_GAIN_SECOND_RST;
        end
        else if (wr_hit && lane0)
        begin
            if (hit(avs_address, SAFE_IDX_GAIN_FIRST))
                gain_first_q <= avs_writedata[5:0];
            if (hit(avs_address, SAFE_IDX_GAIN_SECOND))
                gain_second_q <= avs_writedata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Two identical amplifier channels
    safe_amp_channel u_amp0
    (
        .clk            (clk),
        .rst_n          (rst_n),
        .ctrl_we        (wr_hit & lane0 & hit(avs_address, SAFE_IDX_AMP0_CTRL)),
        .trim_we        (wr_hit & lane0 & hit(avs_address, SAFE_IDX_AMP0_TRIM)),
        .wdata          (avs_writedata[7:0]),
        .amp_out_raw    (amp0_output_status),
        .ctrl_rd        (c0_rd),
        .trim_rd        (t0_rd),
        .enable         (a0_en),
        .bandwidth      (a0_bw),
        .cal_mode       (a0_cal),
        .cal_ref_select (a0_ref),
        .trim_value     (a0_trim)
    );

    // Second channel behaves the same on its own amplifier
    safe_amp_channel u_amp1
    (
        .clk            (clk),
        .rst_n          (rst_n),
        .ctrl_we        (wr_hit & lane0 & hit(avs_address, SAFE_IDX_AMP1_CTRL)),
        .trim_we        (wr_hit & lane0 & hit(avs_address, SAFE_IDX_AMP1_TRIM)),
        .wdata          (avs_writedata[7:0]),
        .amp_out_raw    (amp1_output_status),
        .ctrl_rd        (c1_rd),
        .trim_rd        (t1_rd),
        .enable         (a1_en),
        .bandwidth      (a1_bw),
        .cal_mode       (a1_cal),
        .cal_ref_select (a1_ref),
        .trim_value     (a1_trim)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read mux
    always_comb
    begin
        rd_d = 8'h00;
        unique case (avs_address)
            SAFE_IDX_GAIN_FIRST:  rd_d = {2'b00, gain_first_q};
            SAFE_IDX_GAIN_SECOND: rd_d = gain_second_q;
            SAFE_IDX_AMP0_CTRL:   rd_d = c0_rd;
            SAFE_IDX_AMP1_CTRL:   rd_d = c1_rd;
            SAFE_IDX_AMP0_TRIM:   rd_d = t0_rd;
            SAFE_IDX_AMP1_TRIM:   rd_d = t1_rd;
            default:              rd_d = 8'h00;   // Unmapped reads as zero
        endcase
    end

    // Read data and response registered with the answer cycle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            avs_readdata <= 32'h0000_0000;
            avs_response <= 2'h0;
        end
        else if ((avs_read | avs_write) && !ack_q)
        begin
            avs_readdata <= avs_read ? {24'h00_0000, rd_d} : 32'h0000_0000;
            // Unmapped address answers DECODEERROR
            avs_response <= map_ok ? 2'h0 : 2'h3;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Analog outputs, all from flip-flops
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            first_resistor_code  <= 6'h00;
            second_resistor_code <= 6'h00;
            third_resistor_code  <= 2'h0;
            amp0_enable          <= 1'b0;
            amp1_enable          <= 1'b0;
            amp0_bandwidth       <= SAFE_BW_5K;
            amp1_bandwidth       <= SAFE_BW_5K;
            amp0_cal_mode        <= 1'b0;
            amp1_cal_mode        <= 1'b0;
            amp0_cal_ref_select  <= 1'b0;
            amp1_cal_ref_select  <= 1'b0;
            amp0_trim_value      <= SAFE_TRIM_RST[5:0];
            amp1_trim_value      <= SAFE_TRIM_RST[5:0];
            amp0_cal_switches    <= 1'b0;
            amp1_cal_switches    <= 1'b0;
        end
        else
        begin
            // Code zero still maps to a nonzero resistor in the analog array
            first_resistor_code  <= gain_first_q;
            second_resistor_code <= gain_second_q[5:0];
            third_resistor_code  <= gain_second_q[7:6];
            amp0_enable          <= a0_en;
            amp1_enable          <= a1_en;
            amp0_bandwidth       <= a0_bw;
            amp1_bandwidth       <= a1_bw;
            amp0_cal_mode        <= a0_cal;
            amp1_cal_mode        <= a1_cal;
            amp0_cal_ref_select  <= a0_ref;
            amp1_cal_ref_select  <= a1_ref;
            amp0_trim_value      <= a0_trim;
            amp1_trim_value      <= a1_trim;
            // S0 and S2 close when cal mode and ref select are both set
            amp0_cal_switches    <= a0_cal & a0_ref;
            amp1_cal_switches    <= a1_cal & a1_ref;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    wait_one_a: assert property (@(posedge clk) disable iff (!rst_n)
        ((avs_read | avs_write) && !ack_q) |=> !avs_waitrequest)
        else $error("answer not one cycle after request");

    gain_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        (avs_read && !avs_waitrequest && avs_address == SAFE_IDX_GAIN_FIRST)
        |-> avs_readdata[7:6] == 2'b00)
        else $error("first gain top bits not zero");

    ctrl_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        (avs_read && !avs_waitrequest && avs_address == SAFE_IDX_AMP0_CTRL)
        |-> (avs_readdata[7] == 1'b0 && avs_readdata[4:2] == 3'b000))
        else $error("control unimplemented bits not zero");

    // Read data and cal output are captured on the same edge, so they agree
    status_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        (avs_read && !avs_waitrequest && avs_address == SAFE_IDX_AMP0_CTRL
         && !amp0_cal_mode) |-> !avs_readdata[SAFE_CTRL_STATUS_BIT])
        else $error("amp0 status read outside cal mode");

    gain_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_hit && lane0 && avs_address == SAFE_IDX_GAIN_SECOND)
        |=> ##1 (third_resistor_code == $past(avs_writedata[7:6], 2)
                 && second_resistor_code == $past(avs_writedata[5:0], 2)))
        else $error("second gain write not applied");

    first_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_hit && lane0 && avs_address == SAFE_IDX_GAIN_FIRST)
        |=> ##1 first_resistor_code == $past(avs_writedata[5:0], 2))
        else $error("first gain write not applied");

    en_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_hit && lane0 && avs_address == SAFE_IDX_AMP1_CTRL)
        |=> ##1 (amp1_enable == $past(avs_writedata[6], 2)
                 && amp1_bandwidth == $past(avs_writedata[1:0], 2)))
        else $error("amp1 control write not applied");

    bw_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_hit && lane0 && avs_address == SAFE_IDX_AMP0_CTRL)
        |=> ##1 amp0_bandwidth == $past(avs_writedata[1:0], 2))
        else $error("amp0 bandwidth write not applied");

    trim_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_hit && lane0 && avs_address == SAFE_IDX_AMP0_TRIM)
        |=> ##1 (amp0_trim_value == $past(avs_writedata[5:0], 2)
                 && amp0_cal_mode == $past(avs_writedata[7], 2)
                 && amp0_cal_ref_select == $past(avs_writedata[6], 2)))
        else $error("amp0 trim write not applied");

    // Switches of both channels follow their own cal and ref outputs
    switch_close_a: assert property (@(posedge clk) disable iff (!rst_n)
        (amp0_cal_switches == (amp0_cal_mode && amp0_cal_ref_select))
        && (amp1_cal_switches == (amp1_cal_mode && amp1_cal_ref_select)))
        else $error("cal switches wrong");

    // A trim write with cal and ref both set closes the switches two edges on
    switch_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_hit && lane0 && avs_address == SAFE_IDX_AMP1_TRIM)
        |=> ##1 amp1_cal_switches == ($past(avs_writedata[7], 2)
                                      && $past(avs_writedata[6], 2)))
        else $error("amp1 switches not set by trim write");

    cal_sweep_c: cover property (@(posedge clk) disable iff (!rst_n)
        amp0_cal_switches ##1 $changed(amp0_trim_value));
    status_read_c: cover property (@(posedge clk) disable iff (!rst_n)
        avs_read && !avs_waitrequest && avs_readdata[5]);
    unmapped_c: cover property (@(posedge clk) disable iff (!rst_n)
        !avs_waitrequest && avs_response == 2'h3);

endmodule : safe_amp_ctrl

// File: test/safe_amp_ctrl_tb.sv
// Self-checking testbench for the smoke AFE amplifier control register bank
`timescale 1ns/100ps
module safe_amp_ctrl_tb;
    import safe_pkg::*;
    ////////////////////////////////////////////////////////////////////////////////
    // Clock, reset and bus master signals
    logic                   clk;
    logic                   rst_n;
    logic [SAFE_ADDR_W-1:0] avs_address;
    logic                   avs_read;
    logic                   avs_write;
    logic [31:0]            avs_writedata;
    logic [3:0]             avs_byteenable;
    logic [31:0]            avs_readdata;
    logic [1:0]             avs_response;
    logic                   avs_waitrequest;
    // Analog side
    logic                   amp0_output_status;
    logic                   amp1_output_status;
    logic [5:0]             first_resistor_code;
    logic [5:0]             second_resistor_code;
    logic [1:0]             third_resistor_code;
    logic [1:0]             amp_enable;
    logic [1:0]             amp0_bandwidth;
    logic [1:0]             amp1_bandwidth;
    logic [1:0]             amp_cal_mode;
    logic [1:0]             amp_cal_ref;
    logic [5:0]             amp0_trim_value;
    logic [5:0]             amp1_trim_value;
    logic [1:0]             amp_switches;
    // Scoreboard counters
    int                     failures;
    int                     n_compared;
    ////////////////////////////////////////////////////////////////////////////////
    safe_amp_ctrl i_safe_amp_ctrl
    (
        .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_response(avs_response), .avs_waitrequest(avs_waitrequest),
        .amp0_output_status(amp0_output_status), .amp1_output_status(amp1_output_status),
        .first_resistor_code(first_resistor_code), .second_resistor_code(second_resistor_code),
        .third_resistor_code(third_resistor_code), .amp0_enable(amp_enable[0]),
        .amp1_enable(amp_enable[1]), .amp0_bandwidth(amp0_bandwidth),
        .amp1_bandwidth(amp1_bandwidth), .amp0_cal_mode(amp_cal_mode[0]),
        .amp1_cal_mode(amp_cal_mode[1]), .amp0_cal_ref_select(amp_cal_ref[0]),
        .amp1_cal_ref_select(amp_cal_ref[1]), .amp0_trim_value(amp0_trim_value),
        .amp1_trim_value(amp1_trim_value), .amp0_cal_switches(amp_switches[0]),
        .amp1_cal_switches(amp_switches[1])
    );
    ////////////////////////////////////////////////////////////////////////////////
    // Free-running 250 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Verdict and end of run, shared by the main sequence and the watchdog
    task automatic end_sim();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // One Avalon cycle; upper data lanes carry junk, which must be ignored
    task automatic bus(input logic wr, input logic [2:0] idx, input logic [7:0] data,
                       input logic [3:0] be, output logic [31:0] rd, output logic [1:0] rsp);
        int n;
        @(posedge clk);
        avs_address    <= idx;
        avs_write      <= wr;
        avs_read       <= ~wr;
        avs_writedata  <= {24'hA5A5A5, data};
        avs_byteenable <= be;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0);
        // The slave answers on the second edge of every access; the watchdog ends a hang
        chk("answer edge", 32'(SAFE_WAIT_CYCLES + 1), n);
        rd = avs_readdata;
        rsp = avs_response;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic wr(input logic [2:0] idx, input logic [7:0] data);
        logic [31:0] d;
        logic [1:0]  r;
        bus(1'b1, idx, data, 4'hF, d, r);
        repeat (2) @(posedge clk);
    endtask : wr
    // Read one register; unmapped places answer with a decode error
    task automatic rd_chk(input logic [2:0] idx, input logic [7:0] exp, input string what);
        logic [31:0] d;
        logic [1:0]  r;
        bus(1'b0, idx, 8'h00, 4'hF, d, r);
        chk(what, {24'h0, exp}, d);
        chk("response", (idx > 3'h5) ? 32'h3 : 32'h0, {30'h0, r});
    endtask : rd_chk
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd_chk(SAFE_IDX_GAIN_FIRST, 8'h00, "gain first rst");
        rd_chk(SAFE_IDX_GAIN_SECOND, 8'h00, "gain second rst");
        rd_chk(SAFE_IDX_AMP0_CTRL, 8'h00, "amp0 ctrl rst");
        rd_chk(SAFE_IDX_AMP1_CTRL, 8'h00, "amp1 ctrl rst");
        rd_chk(SAFE_IDX_AMP0_TRIM, 8'h20, "amp0 trim rst");
        rd_chk(SAFE_IDX_AMP1_TRIM, 8'h20, "amp1 trim rst");
        chk("trim out rst", 32'h820, {amp0_trim_value, amp1_trim_value});
        chk("cal rst", 32'h0, {amp_enable, amp_cal_mode, amp_switches});
    endtask : t_reset
    task automatic t_gain();
        wr(SAFE_IDX_GAIN_FIRST, 8'hFF);
        rd_chk(SAFE_IDX_GAIN_FIRST, 8'h3F, "gain first ro bits");
        chk("first code", 32'h3F, {26'h0, first_resistor_code});
        for (int k = 0; k < 4; k++)
        begin
            wr(SAFE_IDX_GAIN_SECOND, {k[1:0], 6'h15 + k[5:0]});
            rd_chk(SAFE_IDX_GAIN_SECOND, {k[1:0], 6'h15 + k[5:0]}, "gain second");
            chk("third code", k, {30'h0, third_resistor_code});
            chk("second code", 32'h15 + k, {26'h0, second_resistor_code});
        end
    endtask : t_gain
    // Status input held high while calibration is off must read as zero
    task automatic t_ctrl();
        amp0_output_status <= 1'b1;
        amp1_output_status <= 1'b1;
        for (int n = 0; n < 2; n++)
            for (int bw = 0; bw < 4; bw++)
            begin
                wr(SAFE_IDX_AMP0_CTRL + n[2:0], 8'hFC | bw[7:0]);
                rd_chk(SAFE_IDX_AMP0_CTRL + n[2:0], 8'h40 | bw[7:0], "ctrl");
                chk("enable", 32'h1, {31'h0, amp_enable[n]});
                chk("bandwidth", bw, {30'h0, n ? amp1_bandwidth : amp0_bandwidth});
            end
        wr(SAFE_IDX_AMP0_CTRL, 8'h00);
        chk("enable off", 32'h2, {30'h0, amp_enable});
    endtask : t_ctrl
    task automatic t_trim(input int n);
        wr(SAFE_IDX_AMP0_TRIM + n[2:0], 8'h1F);
        chk("trim out", 32'h1F, {26'h0, n ? amp1_trim_value : amp0_trim_value});
        wr(SAFE_IDX_AMP0_TRIM + n[2:0], 8'h40);
        chk("ref only", 32'h4, {amp_cal_ref[n], amp_cal_mode[n], amp_switches[n]});
        wr(SAFE_IDX_AMP0_TRIM + n[2:0], 8'h80);
        chk("cal only", 32'h2, {amp_cal_ref[n], amp_cal_mode[n], amp_switches[n]});
    endtask : t_trim
    // Software search step: set trim and input state, let it settle, read status bit
    task automatic probe(input int n, input int t, input int thr, output logic s);
        logic [31:0] d;
        logic [1:0]  r;
        wr(SAFE_IDX_AMP0_TRIM + n[2:0], 8'hC0 | t[7:0]);
        if (n == 0)
            amp0_output_status <= (t >= thr);
        else
            amp1_output_status <= (t >= thr);
        repeat (4) @(posedge clk);
        bus(1'b0, SAFE_IDX_AMP0_CTRL + n[2:0], 8'h00, 4'hF, d, r);
        s = d[SAFE_CTRL_STATUS_BIT];
    endtask : probe
    task automatic t_cal(input int n, input int thr);
        logic s0;
        logic s;
        int   r1;
        int   r2;
        // Model: inputs already in amp function, reference at the operating level
        probe(n, 0, thr, s0);
        chk("switches", 32'h1 << n, {30'h0, amp_switches});
        r1 = 0;
        do begin r1++; probe(n, r1, thr, s); end while (s === s0 && r1 < 63);
        chk("upward result", thr, r1);
        probe(n, 63, thr, s0);
        r2 = 63;
        do begin r2--; probe(n, r2, thr, s); end while (s === s0 && r2 > 0);
        chk("downward result", thr - 1, r2);
        {amp1_output_status, amp0_output_status} <= 2'b11;
        wr(SAFE_IDX_AMP0_TRIM + n[2:0], 8'((r1 + r2) / 2));
        // Status held high must read low once cal is off; amp1 keeps enable and bandwidth
        rd_chk(SAFE_IDX_AMP0_CTRL + n[2:0], n ? 8'h43 : 8'h00, "status after cal");
        chk("final trim", thr - 1, {26'h0, n ? amp1_trim_value : amp0_trim_value});
    endtask : t_cal
    // Unmapped places, junk lanes and a disabled byte lane
    task automatic t_bus();
        logic [31:0] d;
        logic [1:0]  r;
        rd_chk(3'h6, 8'h00, "unmapped read");
        bus(1'b1, 3'h7, 8'hFF, 4'hF, d, r);
        bus(1'b1, SAFE_IDX_GAIN_FIRST, 8'h2A, 4'hE, d, r);
        rd_chk(SAFE_IDX_GAIN_FIRST, 8'h3F, "lane 0 off");
        rd_chk(SAFE_IDX_AMP1_TRIM, 8'h27, "after unmapped write");
    endtask : t_bus
    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog: the sweeps need about 1600 cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        $display("[FAIL] run length expected done seen timeout");
        end_sim();
    end
    // Main sequence
    initial
    begin
        failures = 0;
        n_compared = 0;
        rst_n = 1'b0;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        avs_byteenable = 4'h0;
        amp0_output_status = 1'b0;
        amp1_output_status = 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_gain();
        t_ctrl();
        t_trim(0);
        t_trim(1);
        t_cal(0, 23);
        t_cal(1, 40);
        t_bus();
        end_sim();
    end
endmodule : safe_amp_ctrl_tb
